// File: sfe_map.svh
`ifndef SFE_MAP_SVH
`define SFE_MAP_SVH

// command opcodes
`define SFE_OP_WREN 8'h06
`define SFE_OP_WRDI 8'h04
`define SFE_OP_BE4 8'h20
`define SFE_OP_BE32 8'h52
`define SFE_OP_BE64 8'hD8
`define SFE_OP_CE1 8'h60
`define SFE_OP_CE2 8'hC7
`define SFE_OP_PROT 8'h36

// address layout
`define SFE_ADDR_W 24
`define SFE_ADDR_BYTES 3'h4
`define SFE_LOW_4K 5'hC
`define SFE_LOW_32K 5'hF
`define SFE_LOW_64K 5'h10
`define SFE_LOW_CHIP 5'h18

// reset values
`define SFE_PROT_RST 1'h1
`define SFE_SYNC_RST 3'h1

// timing
`define SFE_CLK_MHZ 200
`define SFE_BLK_ERASE_TIME_US 50
`define SFE_CHIP_ERASE_TIME_US 2000

`endif

// File: sfe_pkg.sv
`default_nettype none
package sfe_pkg;
  typedef enum logic [1:0] {
    SFE_IDLE = 2'h1,
    SFE_ERASE = 2'h2
  } sfe_state_t;
endpackage : sfe_pkg
`default_nettype wire

// File: sfe_flash_cmd.sv
// Behaviour
// - decode 20h/52h/D8h as 4K/32K/64K erase; erase sets region bits to one
// - block erase needs the write latch set by an earlier write enable
// - block erase takes opcode plus three address bytes, starts at release
// - ignore low 12, 15 or 16 address bits by erase size
// - skip block erase when any sector in the span is protected
// - clear write latch when block erase aborts for address or protection
// - show busy during erase and clear write latch before it ends
// - verify erased bytes and set the error flag on a failure
// - 60h and C7h erase the whole array at release, no address
// - chip erase needs the write latch previously set
// - no chip erase on bad framing; protected sector clears latch
// - write enable sets the latch at release; bad framing leaves it
// - guarded commands run only if latch was set when issued
// - write disable clears the latch at release; bad framing leaves it
// - write disable ends sequential program mode
// - one protect bit per sector, one forbids change, reset to one
// - protect command sets addressed sector bit and clears latch
// - bad protect framing leaves bit unchanged, still clears latch
// - lock flag makes protect ignored but still clears the latch
`timescale 1ns/100ps
`default_nettype none
`include "sfe_map.svh"
module sfe_flash_cmd #(
  parameter int NUM_SECT = 16,
  parameter int SECT_SHIFT = 16,
  parameter int SW = $clog2(NUM_SECT),
  parameter int BLK_ERASE_CYC = `SFE_BLK_ERASE_TIME_US * `SFE_CLK_MHZ,
  parameter int CHIP_ERASE_CYC = `SFE_CHIP_ERASE_TIME_US * `SFE_CLK_MHZ
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sck,
  input wire logic csn,
  input wire logic mosi,
  input wire logic protection_lock_flag,
  input wire logic array_verify_fail,
  input wire logic seq_prog_enter,
  input wire logic sector_unprotect,
  input wire logic [SW-1:0] sector_unprotect_idx,
  output logic busy,
  output logic write_latch_flag,
  output logic erase_program_error_flag,
  output logic seq_prog_mode,
  output logic erase_start,
  output logic erase_all,
  output logic [`SFE_ADDR_W-1:0] erase_base,
  output logic [4:0] erase_low_bits,
  output logic [NUM_SECT-1:0] sector_prot
);
  import sfe_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // serial clock side
  logic fresh_reg;
  logic [2:0] bit_cnt_reg;
  logic [2:0] sck_cnt;
  logic [6:0] shift_reg;
  logic [7:0] byte_hold_reg;
  logic byte_tog_reg;
  logic partial_reg;

  // the counter restarts on the first edge of a frame; the byte-boundary
  // flag is taken on every edge, so it holds its last value after release
  assign sck_cnt = fresh_reg ? 3'h0 : bit_cnt_reg;

  always_ff @(posedge sck or posedge csn or negedge resetn)
  begin
    if (csn || !resetn)
      fresh_reg <= 1'h1;
    else
      fresh_reg <= 1'h0;
  end

  always_ff @(posedge sck or negedge resetn)
  begin
    if (!resetn)
    begin
      bit_cnt_reg <= 3'h0;
      partial_reg <= 1'h0;
      shift_reg <= 7'h00;
    end
    else
    begin
      bit_cnt_reg <= sck_cnt + 3'h1;
      partial_reg <= (sck_cnt != 3'h7);
      shift_reg <= {shift_reg[5:0], mosi};
    end
  end

  // the held byte stays still for eight serial clocks after the toggle
  always_ff @(posedge sck or negedge resetn)
  begin
    if (!resetn)
    begin
      byte_hold_reg <= 8'h00;
      byte_tog_reg <= 1'h0;
    end
    else if (sck_cnt == 3'h7)
    begin
      byte_hold_reg <= {shift_reg, mosi};
      byte_tog_reg <= ~byte_tog_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // crossing into clk: three stages, a change counts once two agree
  logic [2:0] x_in;
  logic [2:0] lvl;
  localparam logic [2:0] SYNC_RST = `SFE_SYNC_RST;

  assign x_in = {partial_reg, byte_tog_reg, csn};

  for (genvar gi = 0; gi < 3; gi++)
  begin : g_sync
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic l_reg;
    always_ff @(posedge clk)
    begin
      if (!resetn)
      begin
        s1_reg <= SYNC_RST[gi];
        s2_reg <= SYNC_RST[gi];
        s3_reg <= SYNC_RST[gi];
        l_reg <= SYNC_RST[gi];
      end
      else
      begin
        s1_reg <= x_in[gi];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (s2_reg == s3_reg)
          l_reg <= s3_reg;
      end
    end
    assign lvl[gi] = l_reg;
  end

  //////////////////////////////////////////////////////////////////////
  // framing
  logic cs_prev_reg;
  logic tog_seen_reg;
  logic rel_reg;
  logic frame_start;
  logic frame_end;
  logic byte_evt;

  assign frame_start = cs_prev_reg && !lvl[0];
  assign frame_end = !cs_prev_reg && lvl[0];
  assign byte_evt = (lvl[1] != tog_seen_reg);

  // release is acted on one cycle late so the last byte lands first
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cs_prev_reg <= 1'h1;
      tog_seen_reg <= 1'h0;
      rel_reg <= 1'h0;
    end
    else
    begin
      cs_prev_reg <= lvl[0];
      tog_seen_reg <= lvl[1];
      rel_reg <= frame_end;
    end
  end

  logic [2:0] nbytes_reg;
  logic [7:0] op_reg;
  logic [`SFE_ADDR_W-1:0] addr_reg;
  logic latch_issue_reg;
  logic latch_reg;

  always_ff @(posedge clk)
  begin
    if (!resetn || frame_start)
    begin
      nbytes_reg <= 3'h0;
      op_reg <= 8'h00;
      addr_reg <= 24'h000000;
      latch_issue_reg <= 1'h0;
    end
    else if (byte_evt && nbytes_reg != `SFE_ADDR_BYTES)
    begin
      nbytes_reg <= nbytes_reg + 3'h1;
      if (nbytes_reg == 3'h0)
      begin
        op_reg <= byte_hold_reg;
        latch_issue_reg <= latch_reg;
      end
      else
        addr_reg <= {addr_reg[15:0], byte_hold_reg};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // decode at release
  logic ok_frame;
  logic whole;
  logic has_addr;
  logic is_blk;
  logic is_chip;
  logic is_wren;
  logic is_wrdi;
  logic is_prot;
  logic [4:0] lowb;
  logic [`SFE_ADDR_W-1:0] mask;
  logic [`SFE_ADDR_W-1:0] blk_base;
  logic [`SFE_ADDR_W-1:0] blk_top;
  logic [SW-1:0] lo_idx;
  logic [SW-1:0] hi_idx;
  logic [SW-1:0] sect_idx;
  logic [NUM_SECT-1:0] in_span;
  logic span_prot;
  logic any_prot;

  // commands arriving during an erase are dropped
  assign ok_frame = rel_reg && !busy && (nbytes_reg != 3'h0);
  assign whole = !lvl[2];
  assign has_addr = (nbytes_reg == `SFE_ADDR_BYTES);
  assign is_blk = ok_frame && (op_reg == `SFE_OP_BE4 || op_reg == `SFE_OP_BE32
                  || op_reg == `SFE_OP_BE64);
  assign is_chip = ok_frame && (op_reg == `SFE_OP_CE1
                   || op_reg == `SFE_OP_CE2);
  assign is_wren = ok_frame && (op_reg == `SFE_OP_WREN);
  assign is_wrdi = ok_frame && (op_reg == `SFE_OP_WRDI);
  assign is_prot = ok_frame && (op_reg == `SFE_OP_PROT);

  assign lowb = (op_reg == `SFE_OP_BE4) ? `SFE_LOW_4K :
                (op_reg == `SFE_OP_BE32) ? `SFE_LOW_32K : `SFE_LOW_64K;
  assign mask = ~(24'hFFFFFF << lowb);
  assign blk_base = addr_reg & ~mask;
  assign blk_top = addr_reg | mask;
  assign lo_idx = blk_base[SECT_SHIFT +: SW];
  assign hi_idx = blk_top[SECT_SHIFT +: SW];
  assign sect_idx = addr_reg[SECT_SHIFT +: SW];
  assign span_prot = |(in_span & sector_prot);
  assign any_prot = |sector_prot;

  logic blk_go;
  logic blk_bad;
  logic chip_go;
  logic chip_bad;
  logic wren_go;
  logic wrdi_go;
  logic prot_any;
  logic prot_go;
  logic start_go;
  logic erase_done;

  assign blk_go = is_blk && latch_issue_reg && has_addr && whole
                  && !span_prot;
  assign blk_bad = is_blk && latch_issue_reg
                   && (!has_addr || !whole || span_prot);
  assign chip_go = is_chip && latch_issue_reg && whole && !any_prot;
  assign chip_bad = is_chip && latch_issue_reg && whole && any_prot;
  assign wren_go = is_wren && whole;
  assign wrdi_go = is_wrdi && whole;
  assign prot_any = is_prot && latch_issue_reg;
  assign prot_go = prot_any && !protection_lock_flag && has_addr
                   && whole;
  assign start_go = blk_go || chip_go;

  //////////////////////////////////////////////////////////////////////
  // sector protection
  for (genvar gj = 0; gj < NUM_SECT; gj++)
  begin : g_sect
    logic p_reg;
    assign in_span[gj] = (SW'(gj) >= lo_idx) && (SW'(gj) <= hi_idx);
    // a protect in the same cycle as an unprotect wins
    always_ff @(posedge clk)
    begin
      if (!resetn)
        p_reg <= `SFE_PROT_RST;
      else if (prot_go && sect_idx == SW'(gj))
        p_reg <= 1'h1;
      else if (sector_unprotect && sector_unprotect_idx == SW'(gj)
               && !protection_lock_flag && !busy)
        p_reg <= 1'h0;
    end
    assign sector_prot[gj] = p_reg;
  end

  //////////////////////////////////////////////////////////////////////
  // write latch and sequential mode
  always_ff @(posedge clk)
  begin
    if (!resetn)
      latch_reg <= 1'h0;
    else if (wren_go)
      latch_reg <= 1'h1;
    else if (wrdi_go || blk_bad || chip_bad || prot_any)
      latch_reg <= 1'h0;
    else if (start_go)
      latch_reg <= 1'h0;
  end

  logic seq_reg;

  always_ff @(posedge clk)
  begin
    if (!resetn)
      seq_reg <= 1'h0;
    else if (wrdi_go)
      seq_reg <= 1'h0;
    else if (seq_prog_enter)
      seq_reg <= 1'h1;
  end

  //////////////////////////////////////////////////////////////////////
  // self-timed erase
  sfe_state_t state_reg;
  logic [31:0] cnt_reg;

  assign erase_done = (state_reg == SFE_ERASE) && (cnt_reg == 32'h0);

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_reg <= SFE_IDLE;
      cnt_reg <= 32'h0;
    end
    else
    begin
      case (state_reg)
        SFE_IDLE:
          if (start_go)
          begin
            state_reg <= SFE_ERASE;
            cnt_reg <= chip_go ? 32'(CHIP_ERASE_CYC - 1) : 32'(BLK_ERASE_CYC - 1);
          end
        SFE_ERASE:
          if (cnt_reg == 32'h0)
            state_reg <= SFE_IDLE;
          else
            cnt_reg <= cnt_reg - 32'h1;
        default:
          state_reg <= SFE_IDLE;
      endcase
    end
  end

  logic start_reg;
  logic all_reg;
  logic [`SFE_ADDR_W-1:0] base_reg;
  logic [4:0] lowb_reg;
  logic err_reg;

  // the array fills the region with ones from base over lowb bits
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      start_reg <= 1'h0;
      all_reg <= 1'h0;
      base_reg <= 24'h000000;
      lowb_reg <= 5'h0;
    end
    else
    begin
      start_reg <= start_go;
      if (start_go)
      begin
        all_reg <= chip_go;
        base_reg <= chip_go ? 24'h000000 : blk_base;
        lowb_reg <= chip_go ? `SFE_LOW_CHIP : lowb;
      end
    end
  end

  // verify result is only looked at on the last erase cycle
  always_ff @(posedge clk)
  begin
    if (!resetn || start_go)
      err_reg <= 1'h0;
    else if (erase_done && array_verify_fail)
      err_reg <= 1'h1;
  end

  assign busy = state_reg[1];
  assign write_latch_flag = latch_reg;
  assign erase_program_error_flag = err_reg;
  assign seq_prog_mode = seq_reg;
  assign erase_start = start_reg;
  assign erase_all = all_reg;
  assign erase_base = base_reg;
  assign erase_low_bits = lowb_reg;

  //////////////////////////////////////////////////////////////////////
  // checks
  logic [31:0] busy_cyc_reg;

  always_ff @(posedge clk)
  begin
    if (!resetn || start_go)
      busy_cyc_reg <= 32'h0;
    else if (busy)
      busy_cyc_reg <= busy_cyc_reg + 32'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_wren;
    rel_reg && !busy && nbytes_reg != 3'h0 && op_reg == `SFE_OP_WREN;
  endsequence

  sequence s_blk;
    rel_reg && !busy && nbytes_reg != 3'h0 && (op_reg == `SFE_OP_BE4
      || op_reg == `SFE_OP_BE32 || op_reg == `SFE_OP_BE64);
  endsequence

  sequence s_prot;
    rel_reg && !busy && nbytes_reg != 3'h0 && op_reg == `SFE_OP_PROT;
  endsequence

  property p_prot_rst;
    $rose(resetn) |-> (&sector_prot);
  endproperty
  a_prot_rst: assert property (p_prot_rst)
    else $error("protect bits not set after reset");

  property p_wren;
    s_wren and (##0 !lvl[2]) |=> write_latch_flag ##1 write_latch_flag;
  endproperty
  a_wren: assert property (p_wren)
    else $error("write enable did not set latch");

  property p_wren_bad;
    s_wren and (##0 lvl[2]) |=> $stable(write_latch_flag);
  endproperty
  a_wren_bad: assert property (p_wren_bad)
    else $error("malformed write enable changed latch");

  property p_wrdi;
    rel_reg && !busy && nbytes_reg != 3'h0 && op_reg == `SFE_OP_WRDI
      && !lvl[2] |=> !write_latch_flag && !seq_prog_mode;
  endproperty
  a_wrdi: assert property (p_wrdi)
    else $error("write disable did not clear latch or mode");

  property p_need_latch;
    $rose(busy) |-> $past(latch_issue_reg) && !write_latch_flag;
  endproperty
  a_need_latch: assert property (p_need_latch)
    else $error("erase started without latch or kept latch");

  property p_len;
    $fell(busy) |-> busy_cyc_reg == (erase_all ? 32'(CHIP_ERASE_CYC)
      : 32'(BLK_ERASE_CYC));
  endproperty
  a_len: assert property (p_len)
    else $error("erase busy length wrong");

  property p_blk_abort;
    s_blk and (##0 (span_prot || !has_addr || lvl[2]))
      |=> !busy && !write_latch_flag && !erase_start;
  endproperty
  a_blk_abort: assert property (p_blk_abort)
    else $error("aborted block erase ran or kept latch");

  property p_base;
    $rose(erase_start) && !erase_all |->
      (erase_base & ~(24'hFFFFFF << erase_low_bits)) == 24'h000000 && busy;
  endproperty
  a_base: assert property (p_base)
    else $error("erase base not aligned");

  property p_chip_prot;
    rel_reg && !busy && (op_reg == `SFE_OP_CE1 || op_reg == `SFE_OP_CE2)
      && nbytes_reg != 3'h0 && any_prot |=> !busy;
  endproperty
  a_chip_prot: assert property (p_chip_prot)
    else $error("chip erase ran with protected sector");

  property p_lock;
    s_prot and (##0 latch_issue_reg && protection_lock_flag)
      |=> $stable(sector_prot) && !write_latch_flag;
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked protect changed bits or kept latch");

  property p_prot_set;
    s_prot and (##0 latch_issue_reg && !protection_lock_flag && has_addr
      && !lvl[2]) |=> sector_prot[$past(sect_idx)] && !write_latch_flag;
  endproperty
  a_prot_set: assert property (p_prot_set)
    else $error("protect did not set sector bit");

  property p_prot_bad;
    s_prot and (##0 latch_issue_reg && (!has_addr || lvl[2]))
      |=> !write_latch_flag;
  endproperty
  a_prot_bad: assert property (p_prot_bad)
    else $error("bad protect kept latch");

  property p_err;
    erase_done && array_verify_fail |=> erase_program_error_flag [*2];
  endproperty
  a_err: assert property (p_err)
    else $error("verify failure not flagged");

endmodule : sfe_flash_cmd
`default_nettype wire

// File: sfe_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module sfe_host_model (
  output logic sck,
  output logic csn,
  output logic mosi
);
  initial
  begin
    sck = 1'b0;
    csn = 1'b1;
    mosi = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one framed transfer at 6 ns per bit; sck only toggles inside the frame
  // n that is not a multiple of eight is a deliberate malformed frame
  task automatic send(input logic [47:0] data, input int n);
    int i;
    // small offset keeps link edges off the system clock edges
    #1.3;
    csn = 1'b0;
    #20;
    for (i = 0; i < n; i++)
    begin
      mosi = data[47-i];
      #3;
      sck = 1'b1;
      #3;
      sck = 1'b0;
    end
    #6;
    csn = 1'b1;
    // released line must not keep showing the last bit
    mosi = ~mosi;
  endtask : send
endmodule : sfe_host_model
`default_nettype wire

// File: sfe_flash_cmd_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sfe_flash_cmd_tb;
  localparam int BLK = 20;
  localparam int CHIP = 40;

  typedef struct {
    logic [7:0] op;
    logic [23:0] addr;
    int n;
    logic latch;
    int st;
    logic [23:0] base;
    logic [4:0] low;
    logic [15:0] prot;
  } sfe_row_t;

  logic clk = 1'b0;
  logic resetn;
  logic lock = 1'b0;
  logic vfail = 1'b0;
  logic seq_enter = 1'b0;
  logic unprot = 1'b0;
  logic [3:0] unprot_idx = 4'h0;
  wire logic sck, csn, mosi;
  logic busy, write_latch_flag, err, seq_mode, erase_start, erase_all;
  logic [23:0] erase_base;
  logic [4:0] erase_low_bits;
  logic [15:0] sector_prot;
  int n_mismatch = 0;
  int checks_done = 0;
  int n_start = 0;
  int n_busy = 0;
  int d_start, d_busy, i;

  sfe_row_t rows [21] = '{
    '{8'h06, 24'h000000, 8, 1'b1, 0, 24'h0, 5'h0, 16'h8000},
    '{8'h20, 24'h012345, 32, 1'b0, 1, 24'h012000, 5'hC, 16'h8000},
    '{8'h20, 24'h012345, 32, 1'b0, 0, 24'h0, 5'h0, 16'h8000},
    '{8'h06, 24'h000000, 8, 1'b1, 0, 24'h0, 5'h0, 16'h8000},
    '{8'h52, 24'h0ABCDE, 40, 1'b0, 1, 24'h0A8000, 5'hF, 16'h8000},
    '{8'h06, 24'h000000, 8, 1'b1, 0, 24'h0, 5'h0, 16'h8000},
    '{8'hD8, 24'h03FFFF, 32, 1'b0, 1, 24'h030000, 5'h10, 16'h8000},
    '{8'h06, 24'h000000, 8, 1'b1, 0, 24'h0, 5'h0, 16'h8000},
    '{8'hD8, 24'h0F1234, 32, 1'b0, 0, 24'h0, 5'h0, 16'h8000},
    '{8'h06, 24'h000000, 8, 1'b1, 0, 24'h0, 5'h0, 16'h8000},
    '{8'h20, 24'h012345, 30, 1'b0, 0, 24'h0, 5'h0, 16'h8000},
    '{8'h06, 24'h000000, 7, 1'b0, 0, 24'h0, 5'h0, 16'h8000},
    '{8'h06, 24'h000000, 8, 1'b1, 0, 24'h0, 5'h0, 16'h8000},
    '{8'h04, 24'h000000, 9, 1'b1, 0, 24'h0, 5'h0, 16'h8000},
    '{8'h04, 24'h000000, 8, 1'b0, 0, 24'h0, 5'h0, 16'h8000},
    '{8'h06, 24'h000000, 24, 1'b1, 0, 24'h0, 5'h0, 16'h8000},
    '{8'h36, 24'h020000, 32, 1'b0, 0, 24'h0, 5'h0, 16'h8004},
    '{8'h06, 24'h000000, 8, 1'b1, 0, 24'h0, 5'h0, 16'h8004},
    '{8'h36, 24'h050000, 28, 1'b0, 0, 24'h0, 5'h0, 16'h8004},
    '{8'h06, 24'h000000, 8, 1'b1, 0, 24'h0, 5'h0, 16'h8004},
    '{8'h20, 24'h021000, 32, 1'b0, 0, 24'h0, 5'h0, 16'h8004}
  };

  always #2.5 clk = ~clk;

  sfe_host_model sfe_host_model_i (
    .sck(sck),
    .csn(csn),
    .mosi(mosi)
  );

  sfe_flash_cmd #(
    .BLK_ERASE_CYC(BLK),
    .CHIP_ERASE_CYC(CHIP)
  ) sfe_flash_cmd_i (
    .clk(clk),
    .resetn(resetn),
    .sck(sck),
    .csn(csn),
    .mosi(mosi),
    .protection_lock_flag(lock),
    .array_verify_fail(vfail),
    .seq_prog_enter(seq_enter),
    .sector_unprotect(unprot),
    .sector_unprotect_idx(unprot_idx),
    .busy(busy),
    .write_latch_flag(write_latch_flag),
    .erase_program_error_flag(err),
    .seq_prog_mode(seq_mode),
    .erase_start(erase_start),
    .erase_all(erase_all),
    .erase_base(erase_base),
    .erase_low_bits(erase_low_bits),
    .sector_prot(sector_prot)
  );

  always @(posedge clk)
  begin
    if (erase_start === 1'b1)
      n_start++;
    if (busy === 1'b1)
      n_busy++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  task automatic stop_test();
    if (n_mismatch == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  // effects land some 6 clk after release; then poll busy instead of waiting worst case
  task automatic run_cmd(input logic [7:0] op, input logic [23:0] addr, input int n);
    int k;
    int s0;
    int b0;
    s0 = n_start;
    b0 = n_busy;
    sfe_host_model_i.send({op, addr, 16'h0000}, n);
    repeat (10) @(posedge clk);
    k = 0;
    while (busy !== 1'b0 && k < 500)
    begin
      @(posedge clk);
      k++;
    end
    repeat (3) @(posedge clk);
    d_start = n_start - s0;
    d_busy = n_busy - b0;
  endtask : run_cmd

  task automatic unprot_sector(input logic [3:0] idx);
    @(posedge clk);
    unprot <= 1'b1;
    unprot_idx <= idx;
    @(posedge clk);
    unprot <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : unprot_sector

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    n_mismatch++;
    stop_test();
  end

  initial
  begin
    // a real falling edge is needed: the link-side flops only clear on it
    resetn <= 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
    chk("sector_prot", 32'h0000FFFF, sector_prot);
    chk("write_latch_flag", 32'h0, write_latch_flag);
    for (i = 0; i < 15; i++)
      unprot_sector(i[3:0]);
    for (i = 0; i < 21; i++)
    begin
      run_cmd(rows[i].op, rows[i].addr, rows[i].n);
      chk("write_latch_flag", rows[i].latch, write_latch_flag);
      chk("erase_starts", rows[i].st, d_start);
      chk("sector_prot", rows[i].prot, sector_prot);
      if (rows[i].st == 1)
      begin
        chk("erase_base", rows[i].base, erase_base);
        chk("erase_low_bits", rows[i].low, erase_low_bits);
        chk("busy_cycles", BLK, d_busy);
        chk("erase_all", 32'h0, erase_all);
      end
    end
    // locked protection bits: protect is dropped but the latch still clears
    @(posedge clk) lock <= 1'b1;
    run_cmd(8'h06, 24'h0, 8);
    run_cmd(8'h36, 24'h030000, 32);
    chk("write_latch_flag", 32'h0, write_latch_flag);
    chk("sector_prot", 32'h00008004, sector_prot);
    @(posedge clk) lock <= 1'b0;
    unprot_sector(4'h2);
    unprot_sector(4'hF);
    chk("sector_prot", 32'h0, sector_prot);
    for (i = 0; i < 2; i++)
    begin
      @(posedge clk) vfail <= (i == 0);
      run_cmd(8'h06, 24'h0, 8);
      run_cmd((i == 0) ? 8'hC7 : 8'h60, 24'h0, 8 + 16 * i);
      chk("erase_starts", 32'h1, d_start);
      chk("erase_all", 32'h1, erase_all);
      chk("erase_base", 32'h0, erase_base);
      chk("erase_low_bits", 32'h18, erase_low_bits);
      chk("busy_cycles", CHIP, d_busy);
      chk("write_latch_flag", 32'h0, write_latch_flag);
      chk("error_flag", (i == 0), err);
    end
    run_cmd(8'h06, 24'h0, 8);
    run_cmd(8'hC7, 24'h0, 6);
    chk("erase_starts", 32'h0, d_start);
    chk("write_latch_flag", 32'h1, write_latch_flag);
    run_cmd(8'h36, 24'h070000, 32);
    run_cmd(8'h06, 24'h0, 8);
    run_cmd(8'h60, 24'h0, 8);
    chk("erase_starts", 32'h0, d_start);
    chk("write_latch_flag", 32'h0, write_latch_flag);
    @(posedge clk) seq_enter <= 1'b1;
    @(posedge clk) seq_enter <= 1'b0;
    repeat (2) @(posedge clk);
    chk("seq_prog_mode", 32'h1, seq_mode);
    run_cmd(8'h04, 24'h0, 8);
    chk("seq_prog_mode", 32'h0, seq_mode);
    // second reset in mid-run restores full protection
    @(posedge clk) resetn <= 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    chk("sector_prot", 32'h0000FFFF, sector_prot);
    chk("busy", 32'h0, busy);
    stop_test();
  end
endmodule : sfe_flash_cmd_tb
`default_nettype wire
